// ===== inc/uart_irq_defs.svh
// Constants for the UART interrupt, threshold and alias block
// Function
// - Bus logic and serial logic are separate clock domains, crossing via synchronisers.
// - Serial side settles new configuration within eight slow-clock cycles; software waits.
// - Single interrupt output is high while any enabled source is active.
// - Identifier reads 0001 when idle; only the top-priority source is reported.
// - Receiver line errors give identifier 0110, highest; line status read clears.
// - Receive data available is 0100; set by char or trigger level.
// - FIFO mode timeout 1100 after four idle character times; buffer read clears.
// - Transmit-empty 0010; cleared by identifier read, holding write, or above threshold.
// - Interrupt enable bit 7 selects threshold mode when FIFOs are enabled.
// - Two-bit field selects threshold: empty, 2 entries, quarter or half.
// - In threshold mode line status bit 5 reports transmit FIFO full.
// - FIFO enable cleared disables threshold mode; bit 5 reflects empty.
// - Receive alias range reads the receive buffer at every address.
// - Transmit alias range writes the holding register at every address.
// - FIFO-enable alias accesses only FIFO control bit 0.
// - Receive-trigger alias accesses only FIFO control bits 7 to 6.
// - Transmit-threshold alias accesses only FIFO control bits 5 to 4.
// - A bit period is 16 baud ticks; sampling near mid-bit.
`ifndef UART_IRQ_DEFS_SVH
`define UART_IRQ_DEFS_SVH
`define A_DATA 8'h00
`define A_IER 8'h01
`define A_IIR_FCR 8'h02
`define A_LSR 8'h05
`define A_ALIAS_HI 4'h1
`define A_FE_ALIAS 8'h22
`define A_RT_ALIAS 8'h23
`define A_TT_ALIAS 8'h24
`define FIFO_DEPTH 5'h10
`define IID_NONE 4'h1
`define IID_RLS 4'h6
`define IID_RDA 4'h4
`define IID_TO 4'hC
`define IID_TX_EMPTY_FLAG 4'h2
`define IER_RDA 0
`define IER_TX_EMPTY_FLAG 1
`define IER_RLS 2
`define IER_MODE 7
`define TRIG_L0 5'h01
`define TRIG_L1 5'h04
`define TRIG_L2 5'h08
`define TRIG_L3 5'h0E
`define THR_L0 5'h00
`define THR_L1 5'h02
`define THR_L2 5'h04
`define THR_L3 5'h08
`define TICKS_PER_BIT 16
`define BITS_PER_CHAR 10
`define TO_CHARS 4
`define TO_TICKS 10'(`TO_CHARS * `BITS_PER_CHAR * `TICKS_PER_BIT)
`define SETTLE_CYCLES 4'h8
`endif

// ===== inc/uart_irq_pkg.sv
// Types shared by the UART interrupt block
package uart_irq_pkg;
  typedef logic [3:0] iid_t;
  typedef logic [3:0] ptr_t;
  typedef logic [4:0] lvl_t;
endpackage : uart_irq_pkg

// ===== hdl/uart_irq.sv
// UART interrupt identification, threshold mode, FIFOs and register aliases
`include "uart_irq_defs.svh"
module uart_irq (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_rx_tog,
  input wire logic [7:0] i_rx_data,
  input wire logic [2:0] i_rx_err,
  input wire logic i_tx_tog,
  input wire logic i_baud_tog,
  output logic [7:0] o_tx_data,
  output logic o_tx_valid,
  output logic o_cfg_settle,
  output logic o_fifo_en,
  output logic o_irq,
  output logic [3:0] o_iid
);
  logic [2:0] sync1_r, sync2_r, sync3_r;
  logic rx_ev, tx_ev, baud_ev;
  logic [7:0] ier_r, fcr_r;
  logic [7:0] rx_mem [16];
  logic [7:0] tx_mem [16];
  uart_irq_pkg::ptr_t rx_wr_r, rx_rd_r, tx_wr_r, tx_rd_r;
  uart_irq_pkg::lvl_t rx_lvl_r, tx_lvl_r, trig_lvl, thr_lvl;
  logic [3:0] lsr_err_r;
  logic [9:0] to_cnt_r;
  logic [3:0] settle_r;
  logic tx_empty_flag_q_r, tx_empty_flag_pend_r;
  logic rx_full, tx_full, rx_push, rx_pop, tx_push, tx_pop;
  logic data_wr, data_rd, iir_rd, lsr_rd, fcr_wr, cfg_wr, fifo_flush;
  logic thr_mode, tx_empty_flag_src, tx_empty_flag_act, rda_act, to_act, rls_act;
  logic [7:0] fcr_nxt;
  uart_irq_pkg::iid_t iid;

  // Serial-domain events arrive as toggles; edge found past the second flop
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      sync3_r <= 3'h0;
    end else begin
      sync1_r <= {i_baud_tog, i_tx_tog, i_rx_tog};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end
  assign rx_ev = sync2_r[0] ^ sync3_r[0];
  assign tx_ev = sync2_r[1] ^ sync3_r[1];
  assign baud_ev = sync2_r[2] ^ sync3_r[2];

  // Address decode
  always_comb begin
    data_wr = 1'b0;
    data_rd = 1'b0;
    if (i_addr == `A_DATA || i_addr[7:4] == `A_ALIAS_HI) begin
      data_wr = i_wr;
      data_rd = i_rd;
    end
  end
  assign iir_rd = i_rd && i_addr == `A_IIR_FCR;
  assign lsr_rd = i_rd && i_addr == `A_LSR;
  assign fcr_wr = i_wr && (i_addr == `A_IIR_FCR || i_addr == `A_FE_ALIAS
                  || i_addr == `A_RT_ALIAS || i_addr == `A_TT_ALIAS);
  assign cfg_wr = fcr_wr || (i_wr && i_addr == `A_IER);

  // Aliases touch only their own control field
  always_comb begin
    fcr_nxt = fcr_r;
    if (i_addr == `A_IIR_FCR) begin
      fcr_nxt = i_wdata;
    end else if (i_addr == `A_FE_ALIAS) begin
      fcr_nxt[0] = i_wdata[0];
    end else if (i_addr == `A_RT_ALIAS) begin
      fcr_nxt[7:6] = i_wdata[1:0];
    end else if (i_addr == `A_TT_ALIAS) begin
      fcr_nxt[5:4] = i_wdata[1:0];
    end
  end
  assign fifo_flush = fcr_wr && (fcr_nxt[0] != fcr_r[0]);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ier_r <= 8'h00;
    end else if (i_wr && i_addr == `A_IER) begin
      ier_r <= i_wdata;
    end
  end

  // Reset pulse bits 1 and 2 are not kept
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      fcr_r <= 8'h00;
    end else if (fcr_wr) begin
      fcr_r <= {fcr_nxt[7:3], 2'h0, fcr_nxt[0]};
    end
  end

  // Serial side settle window after any configuration write
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      settle_r <= 4'h0;
    end else if (cfg_wr) begin
      settle_r <= `SETTLE_CYCLES;
    end else if (settle_r != 4'h0) begin
      settle_r <= settle_r - 4'h1;
    end
  end

  // Levels
  always_comb begin
    case (fcr_r[7:6])
      2'h0: trig_lvl = `TRIG_L0;
      2'h1: trig_lvl = `TRIG_L1;
      2'h2: trig_lvl = `TRIG_L2;
      default: trig_lvl = `TRIG_L3;
    endcase
    case (fcr_r[5:4])
      2'h0: thr_lvl = `THR_L0;
      2'h1: thr_lvl = `THR_L1;
      2'h2: thr_lvl = `THR_L2;
      default: thr_lvl = `THR_L3;
    endcase
  end

  // Without FIFOs each side holds one character
  assign rx_full = fcr_r[0] ? rx_lvl_r == `FIFO_DEPTH : rx_lvl_r != 5'h00;
  assign tx_full = fcr_r[0] ? tx_lvl_r == `FIFO_DEPTH : tx_lvl_r != 5'h00;
  assign rx_push = rx_ev && !rx_full;
  assign rx_pop = data_rd && rx_lvl_r != 5'h00;
  assign tx_push = data_wr && !tx_full;
  assign tx_pop = tx_ev && tx_lvl_r != 5'h00;

  generate
    for (genvar e = 0; e < 16; e++) begin : g_entry
      always_ff @(posedge i_mclk) begin
        if (rx_push && rx_wr_r == 4'(e)) begin
          rx_mem[e] <= i_rx_data;
        end
        if (tx_push && tx_wr_r == 4'(e)) begin
          tx_mem[e] <= i_wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rx_wr_r <= 4'h0;
      rx_rd_r <= 4'h0;
      rx_lvl_r <= 5'h00;
    end else if (fifo_flush || (fcr_wr && fcr_nxt[1])) begin
      rx_wr_r <= 4'h0;
      rx_rd_r <= 4'h0;
      rx_lvl_r <= 5'h00;
    end else begin
      rx_wr_r <= rx_wr_r + 4'(rx_push);
      rx_rd_r <= rx_rd_r + 4'(rx_pop);
      rx_lvl_r <= rx_lvl_r + 5'(rx_push) - 5'(rx_pop);
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      tx_wr_r <= 4'h0;
      tx_rd_r <= 4'h0;
      tx_lvl_r <= 5'h00;
    end else if (fifo_flush || (fcr_wr && fcr_nxt[2])) begin
      tx_wr_r <= 4'h0;
      tx_rd_r <= 4'h0;
      tx_lvl_r <= 5'h00;
    end else begin
      tx_wr_r <= tx_wr_r + 4'(tx_push);
      tx_rd_r <= tx_rd_r + 4'(tx_pop);
      tx_lvl_r <= tx_lvl_r + 5'(tx_push) - 5'(tx_pop);
    end
  end

  // Line errors: overrun, parity, framing, break; a new error beats the clear
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      lsr_err_r <= 4'h0;
    end else begin
      lsr_err_r <= (lsr_rd ? 4'h0 : lsr_err_r)
                   | ({4{rx_ev}} & {i_rx_err[2:0], rx_full});
    end
  end

  // Idle count in baud ticks, restarted by any receive FIFO push or pop
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      to_cnt_r <= 10'h000;
    end else if (!fcr_r[0] || rx_lvl_r == 5'h00 || rx_push || rx_pop) begin
      to_cnt_r <= 10'h000;
    end else if (baud_ev && to_cnt_r != `TO_TICKS) begin
      to_cnt_r <= to_cnt_r + 10'h001;
    end
  end

  // Sources
  assign thr_mode = ier_r[`IER_MODE] && fcr_r[0];
  assign tx_empty_flag_src = thr_mode ? tx_lvl_r <= thr_lvl : tx_lvl_r == 5'h00;
  assign rls_act = ier_r[`IER_RLS] && lsr_err_r != 4'h0;
  assign rda_act = ier_r[`IER_RDA]
                   && (fcr_r[0] ? rx_lvl_r >= trig_lvl : rx_lvl_r != 5'h00);
  assign to_act = ier_r[`IER_RDA] && fcr_r[0] && to_cnt_r == `TO_TICKS;
  assign tx_empty_flag_act = ier_r[`IER_TX_EMPTY_FLAG] && (thr_mode ? tx_empty_flag_src : tx_empty_flag_pend_r);

  // Edge-set transmit-empty flag outside threshold mode; set beats clear
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      tx_empty_flag_q_r <= 1'b0;
      tx_empty_flag_pend_r <= 1'b0;
    end else begin
      tx_empty_flag_q_r <= tx_empty_flag_src;
      if (tx_empty_flag_src && !tx_empty_flag_q_r) begin
        tx_empty_flag_pend_r <= 1'b1;
      end else if ((iir_rd && iid == `IID_TX_EMPTY_FLAG) || data_wr) begin
        tx_empty_flag_pend_r <= 1'b0;
      end
    end
  end

  always_comb begin
    if (rls_act) begin
      iid = `IID_RLS;
    end else if (rda_act) begin
      iid = `IID_RDA;
    end else if (to_act) begin
      iid = `IID_TO;
    end else if (tx_empty_flag_act) begin
      iid = `IID_TX_EMPTY_FLAG;
    end else begin
      iid = `IID_NONE;
    end
  end
  assign o_iid = iid;
  assign o_irq = iid != `IID_NONE;

  // Read data, one cycle after the strobe
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (data_rd) begin
      o_rdata <= rx_mem[rx_rd_r];
    end else if (i_rd && i_addr == `A_IER) begin
      o_rdata <= ier_r;
    end else if (iir_rd) begin
      o_rdata <= {{2{fcr_r[0]}}, 2'h0, iid};
    end else if (lsr_rd) begin
      o_rdata <= {1'b0, tx_lvl_r == 5'h00, thr_mode ? tx_full : tx_lvl_r == 5'h00,
                  lsr_err_r[3], lsr_err_r[2], lsr_err_r[1], lsr_err_r[0],
                  rx_lvl_r != 5'h00};
    end else if (i_rd && i_addr == `A_FE_ALIAS) begin
      o_rdata <= {7'h00, fcr_r[0]};
    end else if (i_rd && i_addr == `A_RT_ALIAS) begin
      o_rdata <= {6'h00, fcr_r[7:6]};
    end else if (i_rd && i_addr == `A_TT_ALIAS) begin
      o_rdata <= {6'h00, fcr_r[5:4]};
    end else if (i_rd) begin
      o_rdata <= 8'h00;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_tx_data <= 8'h00;
    end else begin
      o_tx_data <= tx_mem[tx_rd_r];
    end
  end
  assign o_tx_valid = tx_lvl_r != 5'h00;
  assign o_cfg_settle = settle_r != 4'h0;
  assign o_fifo_en = fcr_r[0];

  // Checks
  idle_code_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !o_irq |-> o_iid == `IID_NONE) else $error("idle identifier wrong");
  err_first_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    rls_act |-> o_iid == `IID_RLS) else $error("line error not top priority");
  err_clear_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    lsr_rd && !rx_ev |=> lsr_err_r == 4'h0) else $error("line status read kept errors");
  irq_src_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_irq == (rls_act || rda_act || to_act || tx_empty_flag_act)) else $error("irq mismatch");
  settle_len_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    cfg_wr |=> o_cfg_settle [*8])
    else $error("settle window too short");
  settle_end_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    cfg_wr ##1 !cfg_wr [*8] |=> !o_cfg_settle)
    else $error("settle window too long");
  lsr5_mode_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    lsr_rd && thr_mode |=> o_rdata[5] == $past(tx_full)) else $error("bit 5 not full");
  tx_empty_flag_wr_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    data_wr && !thr_mode && !(tx_empty_flag_src && !tx_empty_flag_q_r) |=> !tx_empty_flag_pend_r)
    else $error("holding write kept empty flag");
  fe_alias_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_wr && i_addr == `A_FE_ALIAS |=> fcr_r[7:4] == $past(fcr_r[7:4]))
    else $error("enable alias touched other bits");
  to_mode_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !fcr_r[0] |-> !to_act) else $error("timeout outside FIFO mode");
  rx_alias_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_rd && i_addr[7:4] == `A_ALIAS_HI && rx_lvl_r != 5'h00 |=> rx_lvl_r < $past(rx_lvl_r)
    || $past(rx_push)) else $error("alias read missed buffer");
  cov_timeout_c: cover property (@(posedge i_mclk) disable iff (i_rst) o_iid == `IID_TO);
  cov_thr_c: cover property (@(posedge i_mclk) disable iff (i_rst) thr_mode && tx_empty_flag_act);
  cov_err_c: cover property (@(posedge i_mclk) disable iff (i_rst) rls_act ##1 lsr_rd);
endmodule : uart_irq

// ===== tb/serial_peer.sv
// Serial-side model: feeds received characters, drains the transmit FIFO, ticks baud
module serial_peer (
  input wire logic i_mclk,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  input wire logic i_stall,
  output logic o_rx_tog,
  output logic [7:0] o_rx_data,
  output logic [2:0] o_rx_err,
  output logic o_tx_tog,
  output logic o_baud_tog,
  output logic [7:0] o_got,
  output logic o_got_stb
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] gap = 4'h0;
  logic valid_d = 1'b0;

  initial begin
    o_rx_tog = 1'b0;
    o_rx_data = 8'h00;
    o_rx_err = 3'h0;
    o_tx_tog = 1'b0;
    o_baud_tog = 1'b0;
    o_got = 8'h00;
    o_got_stb = 1'b0;
  end

  // Pop only once the registered head copy has caught up; pops kept well apart
  always @(posedge i_mclk) begin
    o_got_stb <= 1'b0;
    valid_d <= i_tx_valid;
    if (gap != 4'h0) begin
      gap <= gap - 4'h1;
    end else if (i_tx_valid && valid_d && !i_stall) begin
      o_got <= i_tx_data;
      o_got_stb <= 1'b1;
      o_tx_tog <= ~o_tx_tog;
      gap <= 4'h7;
    end
  end

  // Data and error flags stay put until the next character
  task automatic send_char(input logic [7:0] d, input logic [2:0] e);
    @(posedge i_mclk);
    o_rx_data <= d;
    o_rx_err <= e;
    o_rx_tog <= ~o_rx_tog;
    repeat (6) @(posedge i_mclk);
  endtask : send_char

  // Five clocks per tick keeps baud below a quarter of the bus clock
  task automatic run_baud(input int n);
    repeat (n) begin
      repeat (5) @(posedge i_mclk);
      o_baud_tog <= ~o_baud_tog;
    end
  endtask : run_baud
endmodule : serial_peer

// ===== tb/uart_irq_test.sv
// Self-checking bench for the UART interrupt, threshold and alias block
`include "uart_irq_defs.svh"
module uart_irq_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, wr_en, rd_en, rx_tog, tx_tog, baud_tog, tx_valid;
  logic settle, fifo_en, irq, stall, got_stb;
  logic [7:0] addr, wdata, rdata, rx_data, tx_data, got, d;
  logic [2:0] rx_err;
  logic [3:0] iid;
  logic [31:0] seed = 32'h7564;
  int fail_count = 0;
  int cmp_count = 0;
  logic [7:0] rq[$], txq[$], rxc[$];
  logic prev_rd = 1'b0;
  uart_irq_pkg::lvl_t lv;
  uart_irq_pkg::lvl_t tx_holding_reg [4] = '{`THR_L0, `THR_L1, `THR_L2, `THR_L3};

  uart_irq i_dut (.i_mclk(mclk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_en),
    .i_rd(rd_en), .o_rdata(rdata), .i_rx_tog(rx_tog), .i_rx_data(rx_data), .i_rx_err(rx_err),
    .i_tx_tog(tx_tog), .i_baud_tog(baud_tog), .o_tx_data(tx_data), .o_tx_valid(tx_valid),
    .o_cfg_settle(settle), .o_fifo_en(fifo_en), .o_irq(irq), .o_iid(iid));
  serial_peer i_peer (.i_mclk(mclk), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
    .i_stall(stall), .o_rx_tog(rx_tog), .o_rx_data(rx_data), .o_rx_err(rx_err),
    .o_tx_tog(tx_tog), .o_baud_tog(baud_tog), .o_got(got), .o_got_stb(got_stb));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  function automatic logic [7:0] rnd8();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd8

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
  endtask : bus_rd

  // Configuration write, then hold off traffic until the serial side settles
  task automatic cfg(input logic [7:0] a, input logic [7:0] v);
    bus_wr(a, v);
    @(negedge mclk);
    check({7'h00, settle}, 8'h01);
    for (int k = 0; k < 20 && settle !== 1'b0; k++) @(negedge mclk);
  endtask : cfg

  task automatic exp_iid(input logic [3:0] e);
    repeat (4) @(negedge mclk);
    check({4'h0, iid}, {4'h0, e});
    check({7'h00, irq}, {7'h00, e != `IID_NONE});
  endtask : exp_iid

  // Read data are checked at the falling edge in the cycle after the read strobe
  always @(negedge mclk) begin
    if (prev_rd) check(rdata, rq.pop_front());
    if (got_stb) check(got, txq.pop_front());
    prev_rd = rd_en;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    stall = 1'b0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    exp_iid(`IID_NONE);
    // Non-FIFO transmit-empty raised by the drain, cleared by identification read
    cfg(`A_IER, 8'h02);
    d = rnd8();
    txq.push_back(d);
    bus_wr(`A_DATA, d);
    // Let the write clear the flag pending since reset before waiting
    @(negedge mclk);
    for (int k = 0; k < 80 && irq !== 1'b1; k++) @(negedge mclk);
    exp_iid(`IID_TX_EMPTY_FLAG);
    bus_rd(`A_IIR_FCR, {4'h0, `IID_TX_EMPTY_FLAG});
    exp_iid(`IID_NONE);
    // Threshold mode over all four levels with the drain stalled
    cfg(`A_FE_ALIAS, 8'h01);
    check({7'h00, fifo_en}, 8'h01);
    stall <= 1'b1;
    cfg(`A_IER, 8'h82);
    lv = 5'h00;
    for (int c = 0; c < 4; c++) begin
      cfg(`A_TT_ALIAS, 8'(c));
      repeat (tx_holding_reg[c] - lv) bus_wr(`A_DATA, rnd8());
      exp_iid(`IID_TX_EMPTY_FLAG);
      bus_wr(`A_DATA, rnd8());
      exp_iid(`IID_NONE);
      lv = tx_holding_reg[c] + 5'h01;
    end
    bus_rd(`A_TT_ALIAS, 8'h03);
    repeat (`FIFO_DEPTH - lv) bus_wr(`A_DATA, rnd8());
    bus_rd(`A_LSR, 8'h20);
    cfg(`A_FE_ALIAS, 8'h00);
    exp_iid(`IID_TX_EMPTY_FLAG);
    bus_rd(`A_LSR, 8'h60);
    stall <= 1'b0;
    cfg(`A_IER, 8'h05);
    bus_rd(`A_IER, 8'h05);
    // Receive trigger, burst reads, line error, character timeout
    cfg(`A_FE_ALIAS, 8'h01);
    cfg(`A_RT_ALIAS, 8'h01);
    bus_rd(`A_RT_ALIAS, 8'h01);
    bus_rd(`A_FE_ALIAS, 8'h01);
    for (int i = 0; i < 4; i++) begin
      exp_iid(`IID_NONE);
      d = rnd8();
      rxc.push_back(d);
      i_peer.send_char(d, 3'h0);
    end
    exp_iid(`IID_RDA);
    for (int i = 0; i < 4; i++) bus_rd({`A_ALIAS_HI, 4'(i * 5)}, rxc[i]);
    exp_iid(`IID_NONE);
    d = rnd8();
    i_peer.send_char(d, 3'h1);
    exp_iid(`IID_RLS);
    bus_rd(`A_LSR, 8'h65);
    exp_iid(`IID_NONE);
    i_peer.run_baud(600);
    exp_iid(`IID_NONE);
    i_peer.run_baud(60);
    exp_iid(`IID_TO);
    bus_rd(`A_DATA, d);
    exp_iid(`IID_NONE);
    // Transmit alias burst drained by the peer
    for (int i = 0; i < 4; i++) begin
      d = rnd8();
      txq.push_back(d);
      bus_wr({`A_ALIAS_HI, 4'(i * 5)}, d);
    end
    for (int k = 0; k < 200 && txq.size() != 0; k++) @(negedge mclk);
    check(8'(txq.size()), 8'h00);
    repeat (8) @(negedge mclk);
    check({7'h00, tx_valid}, 8'h00);
    tally_and_finish();
  end
endmodule : uart_irq_test
